// >>> bench/abe_exec_asserts.sv
// Handshake and error checks on the execution unit's APB port
`timescale 1ns/1ps
`default_nettype none
module abe_exec_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr
);
    // ==========================================================
    // Helpers
    // Saturating age of the last instruction write; 15 also means never
    logic [3:0] since;
    wire acc = psel && penable;
    wire map = (paddr < 8'h20) && (paddr[1:0] == 2'h0);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            since <= 4'hf;
        else if (acc && pready && pwrite && paddr == 8'h00)
            since <= 4'h0;
        else if (since != 4'hf)
            since <= since + 4'h1;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Assertions
    a_ready_idle:
        assert property (!acc |-> pready) else $error("pready low outside access");
    a_err_unmap:
        assert property (acc && pready && !map |-> pslverr) else $error("no error");
    a_err_map:
        assert property (acc && map |-> !pslverr) else $error("error on mapped word");
    a_err_access:
        assert property (pslverr |-> acc && pready) else $error("stray error");
    a_stall_bound:
        assert property (acc && !pready |-> ##[1:6] pready) else $error("stall too long");
    a_idle_ready:
        assert property (since > 4'h5 && acc && paddr != 8'h1c |-> pready)
        else $error("idle unit stalled");
    a_stall_cause:
        assert property (acc && !pready |-> paddr == 8'h1c || since < 4'h6)
        else $error("stall without cause");
    a_mem_stall:
        assert property (since > 4'h5 && acc && paddr == 8'h1c |-> ##[0:2] pready)
        else $error("memory read too slow");
endmodule // abe_exec_asserts

bind abe_exec_unit abe_exec_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// >>> bench/test_alu_bit_branch_exec.sv
// Self-checking bench for the execution unit, driven over APB
`timescale 1ns/1ps
`default_nettype none
`include "abe_map.vh"
module test_alu_bit_branch_exec;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int fail_count = 0;
    int cmp_count = 0;

    abe_exec_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // ==========================================================
    // Clock, 50 ns period
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ==========================================================
    // Shared tasks
    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; pready is judged mid-cycle so the edge sees settled values
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(negedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(negedge pclk);
            n++;
        end
        if (n == 20)
        begin
            fail_count++;
            give_verdict;
        end
        // prdata is a flop, so its mid-cycle value is what the closing edge samples
        err = pslverr;
        rd = prdata;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    function logic [31:0] ins(input logic [2:0] op, input logic d, input logic [2:0] b,
        input logic [6:0] f, input logic [8:0] k);
        ins = {7'h00, k, 1'b0, f, 1'b0, b, d, op};
    endfunction

    // Expected status word: cycles, skipped, flags {zero, nibble, carry}
    function logic [31:0] st(input logic [1:0] c, input logic s, input logic [2:0] fl);
        st = {18'h0, c, 2'h0, s, 6'h0, fl};
    endfunction

    // ==========================================================
    // Scenarios
    task t_reset;
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'h0);
        rdc(8'h0c, 32'h0);
        rdc(8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask

    task t_add;
        wr(8'h18, 32'h05);
        wr(8'h1c, 32'h8f);
        wr(8'h04, 32'h71);
        wr(8'h00, ins(`ABE_OP_ADD, 1'b0, 3'h0, 7'h05, 9'h0));
        rdc(8'h04, 32'h00);
        rdc(8'h08, st(2'h1, 1'b0, 3'h7));
        wr(8'h00, ins(`ABE_OP_ADDC, 1'b1, 3'h0, 7'h05, 9'h0));
        rdc(8'h1c, 32'h90);
        rdc(8'h04, 32'h00);
        rdc(8'h08, st(2'h1, 1'b0, 3'h2));
        // Top of the direct address range
        wr(8'h18, 32'h7f);
        wr(8'h1c, 32'h0f);
        wr(8'h04, 32'h01);
        wr(8'h00, ins(`ABE_OP_ADD, 1'b1, 3'h0, 7'h7f, 9'h0));
        rdc(8'h1c, 32'h10);
        rdc(8'h04, 32'h01);
    endtask

    task t_shift;
        wr(8'h18, 32'h06);
        wr(8'h1c, 32'h81);
        wr(8'h00, ins(`ABE_OP_ASR, 1'b1, 3'h0, 7'h06, 9'h0));
        rdc(8'h1c, 32'hc0);
        rdc(8'h08, st(2'h1, 1'b0, 3'h3));
        wr(8'h1c, 32'h01);
        wr(8'h00, ins(`ABE_OP_ASR, 1'b0, 3'h0, 7'h06, 9'h0));
        rdc(8'h04, 32'h00);
        rdc(8'h08, st(2'h1, 1'b0, 3'h7));
    endtask

    // Clears every bit position in turn, checking the survivors each time
    task t_bclr;
        wr(8'h1c, 32'hff);
        for (int b = 0; b < 8; b++)
        begin
            wr(8'h00, ins(`ABE_OP_BCLR, 1'b1, b[2:0], 7'h06, 9'h0));
            rdc(8'h1c, {24'h0, 8'hff << (b + 1)});
        end
        rdc(8'h08, st(2'h1, 1'b0, 3'h7));
    endtask

    task t_skip;
        wr(8'h1c, 32'h40);
        wr(8'h0c, 32'h10);
        wr(8'h00, ins(`ABE_OP_SKIPLO, 1'b0, 3'h6, 7'h06, 9'h0));
        rdc(8'h0c, 32'h11);
        rdc(8'h08, st(2'h1, 1'b0, 3'h7));
        wr(8'h00, ins(`ABE_OP_SKIPLO, 1'b0, 3'h0, 7'h06, 9'h0));
        rdc(8'h0c, 32'h13);
        rdc(8'h08, st(2'h2, 1'b1, 3'h7));
    endtask

    task t_jump;
        wr(8'h0c, 32'h200);
        wr(8'h00, ins(`ABE_OP_RJUMP, 1'b0, 3'h0, 7'h00, 9'h100));
        rdc(8'h0c, 32'h101);
        rdc(8'h08, st(2'h2, 1'b0, 3'h7));
        wr(8'h00, ins(`ABE_OP_RJUMP, 1'b0, 3'h0, 7'h00, 9'h0ff));
        rdc(8'h0c, 32'h201);
    endtask

    task t_ind;
        wr(8'h10, 32'h8005);
        wr(8'h14, 32'h0005);
        wr(8'h00, ins(`ABE_OP_ADD, 1'b0, 3'h0, 7'h00, 9'h0));
        rdc(8'h04, 32'h90);
        rdc(8'h08, st(2'h2, 1'b0, 3'h0));
        wr(8'h00, ins(`ABE_OP_ADD, 1'b0, 3'h0, 7'h01, 9'h0));
        rdc(8'h04, 32'h20);
        rdc(8'h08, st(2'h1, 1'b0, 3'h1));
        wr(8'h00, ins(`ABE_OP_SKIPLO, 1'b0, 3'h0, 7'h00, 9'h0));
        rdc(8'h08, st(2'h3, 1'b1, 3'h1));
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_add;
        t_shift;
        t_bclr;
        t_skip;
        t_jump;
        t_ind;
        give_verdict;
    end
endmodule // test_alu_bit_branch_exec
`default_nettype wire

// >>> design/abe_exec_unit.v
// Execution unit for add, add with carry, shift, bit clear, bit skip, jump
// What this block does
// - add accumulator and file register 0..127
// - destination bit picks accumulator or register
// - add with carry includes current carry
// - arithmetic shift right, bit0 into carry
// - clear one selected bit, flags kept
// - skip next on clear bit, idle slot
// - jump to pointer plus one plus offset
// - jump takes two cycles, flags kept
// - indirect with pointer top bit adds cycle
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "abe_map.vh"

module abe_exec_unit #(
    parameter AW = 7,
    parameter PW = 15
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr
);

    localparam S_IDLE = 3'h0;
    localparam S_EXTRA = 3'h1;
    localparam S_READ = 3'h2;
    localparam S_EXEC = 3'h3;
    localparam S_FLUSH = 3'h4;

    reg [2:0] state;
    reg [24:0] instr;
    reg [7:0] acc;
    reg [2:0] flags;
    reg [PW-1:0] pptr;
    reg [15:0] ptr0;
    reg [15:0] ptr1;
    reg [AW-1:0] mem_addr;
    reg skipped;
    reg [1:0] cycles;
    reg [1:0] settle;
    reg busy_d;
    reg [2:0] next_state;
    wire busy;
    wire [7:0] rd_data;

    // ======================================================================
    // Instruction fields
    wire [2:0] op = instr[`ABE_OP_MSB:`ABE_OP_LSB];
    wire dest = instr[`ABE_DEST_BIT];
    wire [2:0] bsel = instr[`ABE_BSEL_MSB:`ABE_BSEL_LSB];
    wire [AW-1:0] faddr = instr[`ABE_FADDR_MSB:`ABE_FADDR_LSB];
    wire [8:0] offs = instr[`ABE_OFFS_MSB:`ABE_OFFS_LSB];

    // Indirect port resolves through the matching pointer pair
    wire ind0 = (faddr == `ABE_IND0_ADDR);
    wire ind1 = (faddr == `ABE_IND1_ADDR);
    wire [AW-1:0] eff_addr = ind0 ? ptr0[AW-1:0] : (ind1 ? ptr1[AW-1:0] : faddr);
    // extra cycle check
    // Judged on the incoming word: instr only loads at the start edge itself
    wire [2:0] new_op = pwdata[`ABE_OP_MSB:`ABE_OP_LSB];
    wire [AW-1:0] new_faddr = pwdata[`ABE_FADDR_MSB:`ABE_FADDR_LSB];
    wire uses_file = (new_op != `ABE_OP_RJUMP);
    wire slow_ind = uses_file && (((new_faddr == `ABE_IND0_ADDR) && ptr0[`ABE_PTR_TOP])
        || ((new_faddr == `ABE_IND1_ADDR) && ptr1[`ABE_PTR_TOP]));

    assign busy = (state != S_IDLE);

    // ======================================================================
    // APB decode
    wire access = psel && penable;
    wire hit_instr = (paddr == `ABE_OFF_INSTR);
    wire hit_acc = (paddr == `ABE_OFF_ACC);
    wire hit_status = (paddr == `ABE_OFF_STATUS);
    wire hit_pptr = (paddr == `ABE_OFF_PPTR);
    wire hit_ptr0 = (paddr == `ABE_OFF_PTR0);
    wire hit_ptr1 = (paddr == `ABE_OFF_PTR1);
    wire hit_maddr = (paddr == `ABE_OFF_MEMADDR);
    wire hit_mdata = (paddr == `ABE_OFF_MEMDATA);
    wire mapped = hit_instr | hit_acc | hit_status | hit_pptr | hit_ptr0 | hit_ptr1
        | hit_maddr | hit_mdata;
    // Any access while executing waits, and one cycle more: read data captured in the
    // last execute cycle would still hold the old register values
    wire stall = busy || busy_d || (hit_mdata && (settle != 2'h0));
    assign pready = access ? !stall : 1'b1;
    assign pslverr = access && !stall && !mapped;
    wire wr_go = access && !stall && pwrite && mapped;
    wire start = wr_go && hit_instr;

    // ======================================================================
    // Arithmetic datapath on the operand read in the previous cycle
    wire cin = (op == `ABE_OP_ADDC) ? flags[`ABE_ST_CARRY] : 1'b0;
    wire [8:0] sum9 = {1'b0, acc} + {1'b0, rd_data} + {8'h00, cin};
    wire [4:0] sum5 = {1'b0, acc[3:0]} + {1'b0, rd_data[3:0]} + {4'h0, cin};
    // top bit kept, low bit out
    wire [7:0] shr = {rd_data[7], rd_data[7:1]};
    wire [7:0] clr = rd_data & ~(8'h01 << bsel);
    wire is_add = (op == `ABE_OP_ADD) || (op == `ABE_OP_ADDC);
    wire [7:0] result = is_add ? sum9[7:0] : ((op == `ABE_OP_ASR) ? shr : clr);
    wire skip_now = (op == `ABE_OP_SKIPLO) && !rd_data[bsel];
    wire two_cyc = skip_now || (op == `ABE_OP_RJUMP);
    // signed offset widened to the pointer
    wire [PW-1:0] offs_ext = {{(PW-9){offs[8]}}, offs};
    wire [PW-1:0] pp_inc = pptr + {{(PW-1){1'b0}}, 1'b1};
    wire in_exec = (state == S_EXEC);

    // bit clear always writes back, add and shift by destination bit, skip and jump never
    wire mem_we_exec = in_exec && ((op == `ABE_OP_BCLR) || ((is_add || op == `ABE_OP_ASR) && dest));
    wire mem_we_bus = wr_go && hit_mdata;

    abe_file_ram #(
        .AW(AW),
        .DW(8)
    ) u_ram (
        .pclk(pclk),
        .wr_en(mem_we_exec | mem_we_bus),
        .wr_addr(busy ? eff_addr : mem_addr),
        .wr_data(busy ? result : pwdata[7:0]),
        .rd_addr(busy ? eff_addr : mem_addr),
        .rd_data(rd_data)
    );

    // ======================================================================
    // Sequencer: read and execute states form one instruction cycle, extra and flush states one each
    always @*
    begin
        next_state = state;
        case (state)
            S_IDLE:
            begin
                if (start)
                begin
                    next_state = slow_ind ? S_EXTRA : S_READ;
                end
            end
            S_EXTRA: next_state = S_READ;
            S_READ: next_state = S_EXEC;
            S_EXEC: next_state = two_cyc ? S_FLUSH : S_IDLE;
            S_FLUSH: next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= S_IDLE;
            cycles <= 2'h0;
            busy_d <= 1'b0;
        end
        else
        begin
            state <= next_state;
            busy_d <= busy;
            if (start)
            begin
                cycles <= 2'h1;
            end
            else if (state == S_EXTRA || state == S_FLUSH)
            begin
                cycles <= cycles + 2'h1;
            end
        end
    end

    // ======================================================================
    // Architectural state: software writes and execution results
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            instr <= 25'h0000000;
            acc <= `ABE_ACC_RST;
            flags <= `ABE_FLAGS_RST;
            pptr <= `ABE_PPTR_RST;
            ptr0 <= `ABE_PTR_RST;
            ptr1 <= `ABE_PTR_RST;
            mem_addr <= {AW{1'b0}};
            skipped <= 1'b0;
        end
        else if (in_exec)
        begin
            // results land at the end of the execute cycle
            if ((is_add || op == `ABE_OP_ASR) && !dest)
            begin
                acc <= result;
            end
            if (is_add)
            begin
                flags[`ABE_ST_CARRY] <= sum9[8];
                flags[`ABE_ST_NIBBLE] <= sum5[4];
                flags[`ABE_ST_ZERO] <= (sum9[7:0] == 8'h00);
            end
            else if (op == `ABE_OP_ASR)
            begin
                flags[`ABE_ST_CARRY] <= rd_data[0];
                flags[`ABE_ST_ZERO] <= (shr == 8'h00);
            end
            if (op == `ABE_OP_RJUMP)
            begin
                pptr <= pp_inc + offs_ext;
            end
            else if (skip_now)
            begin
                pptr <= pp_inc + {{(PW-1){1'b0}}, 1'b1};
            end
            else
            begin
                pptr <= pp_inc;
            end
            skipped <= skip_now;
        end
        else if (wr_go)
        begin
            case (paddr)
                `ABE_OFF_INSTR: instr <= pwdata[24:0];
                `ABE_OFF_ACC: acc <= pwdata[7:0];
                `ABE_OFF_STATUS: flags <= pwdata[2:0];
                `ABE_OFF_PPTR: pptr <= pwdata[PW-1:0];
                `ABE_OFF_PTR0: ptr0 <= pwdata[15:0];
                `ABE_OFF_PTR1: ptr1 <= pwdata[15:0];
                `ABE_OFF_MEMADDR: mem_addr <= pwdata[AW-1:0];
                // Memory data goes straight into the file memory
                default: mem_addr <= mem_addr;
            endcase
        end
    end

    // ======================================================================
    // Read data settles two edges after the memory address moves
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            settle <= 2'h0;
        end
        else if (busy || (wr_go && (hit_maddr || hit_mdata)))
        begin
            settle <= `ABE_SETTLE_CYC;
        end
        else if (settle != 2'h0)
        begin
            settle <= settle - 2'h1;
        end
    end

    // ======================================================================
    // Read data captured from registers every cycle of a read
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else if (psel && !pwrite)
        begin
            case (paddr)
                `ABE_OFF_INSTR: prdata <= {7'h00, instr};
                `ABE_OFF_ACC: prdata <= {24'h000000, acc};
                `ABE_OFF_STATUS: prdata <= {18'h00000, cycles, 2'h0, skipped, busy, 5'h00, flags};
                `ABE_OFF_PPTR: prdata <= {{(32-PW){1'b0}}, pptr};
                `ABE_OFF_PTR0: prdata <= {16'h0000, ptr0};
                `ABE_OFF_PTR1: prdata <= {16'h0000, ptr1};
                `ABE_OFF_MEMADDR: prdata <= {{(32-AW){1'b0}}, mem_addr};
                `ABE_OFF_MEMDATA: prdata <= {24'h000000, rd_data};
                // Unmapped words read as zero
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule // abe_exec_unit

`default_nettype wire

// >>> design/abe_file_ram.v
// Data memory of file registers: one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none

module abe_file_ram #(
    parameter AW = 7,
    parameter DW = 8
) (
    input wire pclk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // ======================================================================
    // Storage; read data always one edge behind the address
    always @(posedge pclk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule // abe_file_ram

`default_nettype wire

// >>> design/abe_map.vh
// Register offsets, field positions and codes for the ALU bit and branch unit
`ifndef ABE_MAP_VH
`define ABE_MAP_VH

// ==========================================================================
// Register byte offsets (APB, one aligned word each)
`define ABE_OFF_INSTR 8'h00
`define ABE_OFF_ACC 8'h04
`define ABE_OFF_STATUS 8'h08
`define ABE_OFF_PPTR 8'h0c
`define ABE_OFF_PTR0 8'h10
`define ABE_OFF_PTR1 8'h14
`define ABE_OFF_MEMADDR 8'h18
`define ABE_OFF_MEMDATA 8'h1c

// ==========================================================================
// Instruction word fields
`define ABE_OP_LSB 0
`define ABE_OP_MSB 2
`define ABE_DEST_BIT 3
`define ABE_BSEL_LSB 4
`define ABE_BSEL_MSB 6
`define ABE_FADDR_LSB 8
`define ABE_FADDR_MSB 14
`define ABE_OFFS_LSB 16
`define ABE_OFFS_MSB 24

// ==========================================================================
// Operation codes
`define ABE_OP_ADD 3'h0
`define ABE_OP_ADDC 3'h1
`define ABE_OP_ASR 3'h2
`define ABE_OP_BCLR 3'h3
`define ABE_OP_SKIPLO 3'h4
`define ABE_OP_RJUMP 3'h5

// ==========================================================================
// Status register fields and reset values
`define ABE_ST_CARRY 0
`define ABE_ST_NIBBLE 1
`define ABE_ST_ZERO 2
`define ABE_ST_BUSY 8
`define ABE_ST_SKIPPED 9
`define ABE_ST_CYC_LSB 12
`define ABE_ST_CYC_MSB 13
`define ABE_FLAGS_RST 3'h0
`define ABE_ACC_RST 8'h00
`define ABE_PPTR_RST 15'h0000
`define ABE_PTR_RST 16'h0000

// ==========================================================================
// File addresses that act as the indirect access ports
`define ABE_IND0_ADDR 7'h00
`define ABE_IND1_ADDR 7'h01
`define ABE_PTR_TOP 15
`define ABE_SETTLE_CYC 2'h2

`endif
